// [rcg_decoder.sv]
// per-chip phase clock gating decoder for a dynamic ram bank
// assumes phase enables and cycle timing pulse come from one system timing generator
// assumes all inputs are synchronous to clk_sys_i and a memory cycle spans several clocks
//
// Functional notes
// - A selected chip gets every phase pulse of that memory cycle.
// - During a refresh cycle every chip gets every phase pulse, whatever its select.
// - In the first cycle after deselection a chip gets one strobe pulse and no other phase.
// - Otherwise a chip gets no clock pulses at all.
// - A late-rising select or refresh delays the strobe edge, so the strobe enable must be wide.
// - A refresh rising while the strobe enable is still high would glitch the strobe.
// - With the clear option, refresh clears the disable flop so a glitch is followed by a full strobe in the next cycle.
// - A refresh cycle is followed by one extra strobe pulse, as a deselect is.
// - A burst of 32 back-to-back refreshes yields 33 strobe pulses.
// - 32 spread-out refreshes yield 64 strobe pulses.
// - Strobe turn-off lags deselection by one cycle; turn-on is immediate.
`timescale 1ns/1ps
`default_nettype none
`include "rcg_regs.svh"
module rcg_decoder
  import rcg_pkg::*;
#(
  parameter int          NUM_CHIPS   = `RCG_NUM_CHIPS,
  parameter bit          REFRESH_CLR = 1'b1
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 cycle_timing_pulse_i,
  input  wire rcg_phase_t           phase_en_i,
  input  wire logic [NUM_CHIPS-1:0] chip_sel_i,
  input  wire logic                 refresh_i,
  output logic      [NUM_CHIPS-1:0] strobe_o,
  output logic      [NUM_CHIPS-1:0] phase2_o,
  output logic      [NUM_CHIPS-1:0] phase3_o
);

  // an empty bank leaves nothing to gate
  if (NUM_CHIPS < 1) begin : g_bad_chips
    $error("NUM_CHIPS must be at least 1");
  end

  // cycle boundary: rising edge of the timing pulse
  logic                 pulse_d;
  logic                 cycle_start;
  // refresh seen at any point of the current cycle, so a short request still counts
  logic                 refresh_held;
  logic                 refresh_eff;
  logic [NUM_CHIPS-1:0] active;
  // delayed-disable state: high while the chip was active last cycle
  logic [NUM_CHIPS-1:0] armed;
  logic [NUM_CHIPS-1:0] next_armed;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_d <= 1'b0;
    end else begin
      pulse_d <= cycle_timing_pulse_i;
    end
  end

  assign cycle_start = cycle_timing_pulse_i & ~pulse_d;

  // with the clear option a refresh request latched in-cycle may be released early
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      refresh_held <= 1'b0;
    end else if (cycle_start) begin
      refresh_held <= 1'b0;
    end else if (refresh_i) begin
      refresh_held <= 1'b1;
    end
  end

  // a refresh held from the last cycle must not count at the boundary, or the
  // cycle after a refresh would be clocked in full and owe a second strobe
  assign refresh_eff = refresh_i | (REFRESH_CLR & refresh_held & ~cycle_start);
  assign active      = chip_sel_i | {NUM_CHIPS{refresh_eff}};

  // armed is only sampled at the cycle boundary, but gate_strobe takes in active on every clock, so a refresh
  // rising while the strobe enable is still high opens the strobe late and can give a partial pulse
  always_comb begin
    next_armed = armed;
    if (cycle_start) begin
      next_armed = active;
    end
    if (REFRESH_CLR && refresh_i) begin
      next_armed = {NUM_CHIPS{1'b1}};
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed <= {NUM_CHIPS{`RCG_ARMED_RST}};
    end else begin
      armed <= next_armed;
    end
  end

  // cycle-held gating: which pulses each chip gets this cycle
  logic [NUM_CHIPS-1:0] gate_full;
  logic [NUM_CHIPS-1:0] gate_strobe;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_full   <= '0;
      gate_strobe <= '0;
    end else if (cycle_start) begin
      gate_full   <= active;
      gate_strobe <= active | armed;
    end else begin
      gate_full   <= gate_full | active;
      gate_strobe <= gate_strobe | active;
    end
  end

  // data outputs from flops; one clock of latency on every phase
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strobe_o <= '0;
      phase2_o <= '0;
      phase3_o <= '0;
    end else begin
      strobe_o <= {NUM_CHIPS{phase_en_i.strobe}} & (cycle_start ? (active | armed) : gate_strobe);
      phase2_o <= {NUM_CHIPS{phase_en_i.phase2}} & gate_full;
      phase3_o <= {NUM_CHIPS{phase_en_i.phase3}} & gate_full;
    end
  end

  // assertions: the gating state of every chip is checked, not only the first
  sequence deselect_s(int i);
    armed[i] && !chip_sel_i[i] && !refresh_eff && cycle_start;
  endsequence

  sequence strobe_only_s(int i);
    gate_strobe[i] && !gate_full[i];
  endsequence

  // built from the raw inputs, so a refresh leaking from the last cycle is seen
  sequence idle_start_s(int i);
    cycle_start && !chip_sel_i[i] && !refresh_i && !armed[i];
  endsequence

  cycle_once_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    cycle_start |=> !cycle_start)
    else $error("memory cycle started twice on one timing pulse");

  refresh_all_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (cycle_start && refresh_i) |=> (&gate_full))
    else $error("refresh did not enable all chips");

  refresh_strobe_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (cycle_start && refresh_i && phase_en_i.strobe) |=> (&strobe_o))
    else $error("refresh strobe withheld from a chip");

  armed_lag_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (cycle_start && !refresh_i) |=> (armed == $past(active)))
    else $error("disable flop did not follow cycle condition");

  refresh_rearm_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (REFRESH_CLR && refresh_i) |=> (&armed))
    else $error("refresh did not clear the disable flop");

  held_set_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (refresh_i && !cycle_start) |=> refresh_held)
    else $error("short refresh request was not held");

  held_clear_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    cycle_start |=> !refresh_held)
    else $error("held refresh survived the cycle boundary");

  for (genvar c = 0; c < NUM_CHIPS; c++) begin : g_chip_chk
    selected_full_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (cycle_start && chip_sel_i[c]) |=> gate_full[c])
      else $error("selected chip lost its phase gating");

    extra_strobe_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      deselect_s(c) |=> strobe_only_s(c))
      else $error("extra strobe missing after deselect");

    disarm_lag_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      deselect_s(c) |=> !armed[c])
      else $error("disable flop still set after the extra strobe");

    idle_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (cycle_start && !armed[c] && !active[c]) |=> !gate_strobe[c] && !gate_full[c])
      else $error("idle chip got clock gating");

    no_refresh_leak_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      idle_start_s(c) |=> (!gate_strobe[c] && !gate_full[c]))
      else $error("idle chip clocked after an earlier refresh");

    turn_on_now_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (cycle_start && chip_sel_i[c] && phase_en_i.strobe) |=> strobe_o[c])
      else $error("strobe late for a newly selected chip");

    full_covers_strobe_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      gate_full[c] |-> gate_strobe[c])
      else $error("phase gating open while strobe gating is shut");

    strobe_gated_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      strobe_o[c] |-> $past(phase_en_i.strobe))
      else $error("strobe without phase enable");

    phase2_gated_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      phase2_o[c] |-> $past(gate_full[c] && phase_en_i.phase2))
      else $error("phase two passed to an idle chip");

    phase3_gated_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      phase3_o[c] |-> $past(gate_full[c] && phase_en_i.phase3))
      else $error("phase three passed to an idle chip");

    phase2_pass_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (gate_full[c] && phase_en_i.phase2) |=> phase2_o[c])
      else $error("phase two withheld from a clocked chip");

    phase3_pass_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (gate_full[c] && phase_en_i.phase3) |=> phase3_o[c])
      else $error("phase three withheld from a clocked chip");
  end

endmodule
`default_nettype wire

// [rcg_regs.svh]
// constants for the ram clock gating decoder
// assumes inclusion by the decoder module only
`ifndef RCG_REGS_SVH
`define RCG_REGS_SVH
`define RCG_NUM_CHIPS       4
`define RCG_ARMED_RST       1'b0
`define RCG_BURST_LEN       32
`endif

// [rcg_pkg.sv]
// types for the ram clock gating decoder
// assumes a single system clock domain
package rcg_pkg;
  typedef struct packed {
    logic strobe;
    logic phase2;
    logic phase3;
  } rcg_phase_t;
endpackage

// [rcg_ram_model.sv]
// dram bank model: counts gated phase pulses seen by each chip
// assumes registered gated phases from the decoder, one clock
`timescale 1ns/1ps
`default_nettype none
module rcg_ram_model #(
  parameter int N = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  input  wire logic [N-1:0] strobe_i,
  input  wire logic [N-1:0] phase2_i,
  input  wire logic [N-1:0] phase3_i,
  output var  int           n_strobe [N],
  output var  int           n_late   [N]
);
  logic [N-1:0] prev_s;
  logic [N-1:0] prev_l;
  // a chip latches select only on a strobe rise, so every rise counts
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    for (int i = 0; i < N; i++) begin
      if (!reset_n_i) begin
        n_strobe[i] = 0;
        n_late[i] = 0;
      end else begin
        n_strobe[i] += int'(strobe_i[i] & ~prev_s[i]);
        n_late[i] += int'(phase2_i[i] & ~prev_l[i]) + int'(phase3_i[i]);
      end
    end
    prev_s = reset_n_i ? strobe_i : '0;
    prev_l = reset_n_i ? phase2_i : '0;
  end
endmodule
`default_nettype wire

// [rcg_decoder_tb.sv]
// testbench for the ram clock gating decoder
// assumes one 8-clock memory cycle per timing pulse, a 2-clock strobe phase and 1-clock phase2/phase3
`timescale 1ns/1ps
`default_nettype none
module rcg_decoder_tb;
  import rcg_pkg::*;
  logic       clk_sys_i            = 1'b0;
  logic       reset_n_i            = 1'b0;
  logic       cycle_timing_pulse_i = 1'b0;
  rcg_phase_t phase_en_i           = '0;
  logic [3:0] chip_sel_i           = 4'h0;
  logic       refresh_i            = 1'b0;
  logic [3:0] strobe_o;
  logic [3:0] phase2_o;
  logic [3:0] phase3_o;
  logic [3:0] armed                = 4'h0;
  int         n_strobe [4];
  int         n_late   [4];
  int         e_s      [4]         = '{default: 0};
  int         e_l      [4]         = '{default: 0};
  int         n_fail               = 0;
  int         n_tests              = 0;
  int         base;
  always #2.5 clk_sys_i = ~clk_sys_i;
  rcg_decoder #(.NUM_CHIPS(4), .REFRESH_CLR(1'b1)) dut (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .cycle_timing_pulse_i(cycle_timing_pulse_i),
    .phase_en_i(phase_en_i), .chip_sel_i(chip_sel_i), .refresh_i(refresh_i),
    .strobe_o(strobe_o), .phase2_o(phase2_o), .phase3_o(phase3_o));
  rcg_ram_model #(.N(4)) chips (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .strobe_i(strobe_o), .phase2_i(phase2_o), .phase3_i(phase3_o),
    .n_strobe(n_strobe), .n_late(n_late));
  task automatic cmp(input int got, input int exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // select held the whole cycle; a short refresh leans on the clear option
  task automatic mem_cycle(input logic [3:0] sel, input logic rf, input bit rf_short = 1'b0);
    @(negedge clk_sys_i);
    chip_sel_i = sel;
    refresh_i = rf;
    for (int k = 0; k < 8; k++) begin
      cycle_timing_pulse_i = (k < 2);
      phase_en_i = '{strobe: k < 2, phase2: k == 3, phase3: k == 5};
      if (rf_short && k == 2) begin
        refresh_i = 1'b0;
      end
      @(negedge clk_sys_i);
    end
    for (int i = 0; i < 4; i++) begin
      e_s[i] += int'(sel[i] | rf | armed[i]);
      e_l[i] += 2 * int'(sel[i] | rf);
    end
    armed = sel | {4{rf}};
  endtask
  task automatic check(input string name);
    for (int i = 0; i < 4; i++) begin
      cmp(n_strobe[i], e_s[i]);
      cmp(n_late[i], e_l[i]);
    end
    $display("test %s done", name);
  endtask
  task automatic t_sel;
    mem_cycle(4'h1, 1'b0);
    mem_cycle(4'h0, 1'b0);
    mem_cycle(4'h0, 1'b0);
    mem_cycle(4'h8, 1'b0);
    check("select");
  endtask
  task automatic t_alt;
    mem_cycle(4'h1, 1'b0);
    mem_cycle(4'h2, 1'b0);
    mem_cycle(4'h1, 1'b0);
    mem_cycle(4'h0, 1'b0);
    check("alternate");
  endtask
  task automatic t_burst;
    base = n_strobe[2];
    repeat (32) mem_cycle(4'h0, 1'b1);
    mem_cycle(4'h0, 1'b0);
    mem_cycle(4'h0, 1'b0);
    cmp(n_strobe[2] - base, 33);
    check("burst");
  endtask
  task automatic t_spread;
    base = n_strobe[1];
    repeat (32) begin
      mem_cycle(4'h0, 1'b1);
      mem_cycle(4'h0, 1'b0);
      mem_cycle(4'h0, 1'b0);
    end
    cmp(n_strobe[1] - base, 64);
    check("spread");
  endtask
  task automatic t_short;
    mem_cycle(4'h0, 1'b1, 1'b1);
    mem_cycle(4'h0, 1'b0);
    mem_cycle(4'h0, 1'b0);
    check("short refresh");
  endtask
  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    t_sel();
    t_alt();
    t_burst();
    t_spread();
    t_short();
    wrap_up();
  end
endmodule
`default_nettype wire
